// File: hdl/cfg_bank_pkg.sv
package cfg_bank_pkg;
   // ****************************************
   // index map
   // ****************************************
   localparam logic [7:0] IDX_LDEV_SEL = 8'h07;
   localparam logic [7:0] IDX_CHIP_ID = 8'h20;
   localparam logic [7:0] IDX_SI_REV = 8'h21;
   localparam logic [7:0] IDX_MODE = 8'h24;
   localparam logic [7:0] IDX_TEST_A = 8'h28;
   localparam logic [7:0] IDX_TEST_B = 8'h29;
   localparam logic [7:0] IDX_TEST_C = 8'h2c;
   localparam logic [7:0] IDX_TEST_D = 8'h2d;
   localparam logic [7:0] IDX_TEST_E = 8'h2e;
   localparam logic [7:0] IDX_TEST_F = 8'h2f;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int MODE_SIRQ_BIT = 2;
   localparam logic [7:0] MODE_WR_MASK = 8'h04;
   localparam logic [7:0] MODE_RST = 8'h04;
   localparam logic [7:0] LDEV_RST = 8'h00;
   localparam logic [7:0] INDEX_RST = 8'h00;
   localparam logic [7:0] TEST_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // arbitrary values, not tied to any part
   localparam logic [7:0] CHIP_ID_DEFAULT = 8'h5a;
   localparam logic [7:0] SI_REV_DEFAULT = 8'h01;
   localparam int NUM_TEST = 6;
endpackage

// File: hdl/activate_bank.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// per logical device activation state
// ****************************************
module activate_bank #(
   parameter int NUM_LDEV = 16
) (
   input wire logic i_clk,
   input wire logic i_sys_rstn,
   input wire logic i_host_rstn,
   input wire logic [7:0] i_ldev_sel,
   input wire logic i_act_we,
   input wire logic i_act_val,
   input wire logic [NUM_LDEV-1:0] i_power_sel,
   output logic [NUM_LDEV-1:0] o_active
);
   initial begin
      if (NUM_LDEV < 1 || NUM_LDEV > 256) begin
         $error("NUM_LDEV out of range");
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_LDEV; g++) begin : g_dev
         logic act_r;
         logic clr;
         // power select picks which reset domain clears this device
         assign clr = i_power_sel[g] ? ~i_host_rstn : ~i_sys_rstn;
         always_ff @(posedge i_clk) begin
            if (clr) begin
               act_r <= 1'b0;
            end else if (i_act_we && i_ldev_sel == 8'(g)) begin
               act_r <= i_act_val;
            end
         end
         assign o_active[g] = act_r;
      end
   endgenerate
endmodule
`default_nettype wire

// File: hdl/global_config_register_bank.sv
// Contract
// - host writes index first; data port then reaches the indexed register.
// - unused global offsets ignore writes and read zero.
// - writing offset 07h selects the current logical device.
// - activation affects only the currently selected logical device.
// - offset 20h reads a fixed identity code; writes ignored.
// - offset 21h reads a fixed silicon revision.
// - bit 2 at 24h enables the serial interrupt interface, default on.
// - other mode bits ignore writes and read zero.
// - mixed registers update writable fields only, keep read-only ones.
// - activation cleared by system or host reset per power-select bit.
// - power-select bit chooses reset domain for activation; index, selector and mode always follow host reset.
`timescale 1ns/100ps
`default_nettype none
module global_config_register_bank
   import cfg_bank_pkg::*;
#(
   parameter int NUM_LDEV = 16,
   parameter logic [7:0] CHIP_ID = CHIP_ID_DEFAULT,
   parameter logic [7:0] SI_REV = SI_REV_DEFAULT
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_system_reset_n,
   input wire logic i_host_domain_reset_n,
   input wire logic i_index_we,
   input wire logic i_data_we,
   input wire logic i_data_re,
   input wire logic [7:0] i_wdata,
   input wire logic i_act_we,
   input wire logic i_act_val,
   input wire logic [NUM_LDEV-1:0] i_power_sel,
   output logic [7:0] o_rdata,
   output logic [7:0] o_index,
   output logic [7:0] o_ldev_sel,
   output logic o_interrupt_serializer_enable,
   output logic [NUM_LDEV-1:0] o_active
);
   initial begin
      if (NUM_LDEV < 1 || NUM_LDEV > 256) begin
         $error("NUM_LDEV out of range");
      end
   end

   // ****************************************
   // reset synchronisers
   // ****************************************
   // system and host resets pass through two flops, so both assert and deassert two clocks late; only i_rstn asserts at once
   logic sys_s1_r;
   logic sys_s2_r;
   logic host_s1_r;
   logic host_s2_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sys_s1_r <= 1'b0;
         sys_s2_r <= 1'b0;
      end else begin
         sys_s1_r <= i_system_reset_n;
         sys_s2_r <= sys_s1_r;
      end
   end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         host_s1_r <= 1'b0;
         host_s2_r <= 1'b0;
      end else begin
         host_s1_r <= i_host_domain_reset_n;
         host_s2_r <= host_s1_r;
      end
   end

   // ****************************************
   // reset qualifiers
   // ****************************************
   // host reset clears the index and the global registers, not the test bytes
   logic host_clr;
   assign host_clr = !host_s2_r;

   // ****************************************
   // index latch
   // ****************************************
   logic [7:0] index_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         index_r <= INDEX_RST;
      end else if (host_clr) begin
         index_r <= INDEX_RST;
      end else if (i_index_we) begin
         index_r <= i_wdata;
      end
   end

   logic wr;
   // index write wins if both strobes arrive together
   assign wr = i_data_we && !i_index_we;

   // ****************************************
   // write decode
   // ****************************************
   // one enable per location so a stray index can never reach two registers
   logic ldev_we;
   logic mode_we;
   assign ldev_we = wr && index_r == IDX_LDEV_SEL;
   assign mode_we = wr && index_r == IDX_MODE;

   // ****************************************
   // logical device selector
   // ****************************************
   logic [7:0] ldev_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ldev_r <= LDEV_RST;
      end else if (host_clr) begin
         ldev_r <= LDEV_RST;
      end else if (ldev_we) begin
         ldev_r <= i_wdata;
      end
   end

   // ****************************************
   // device mode
   // ****************************************
   logic [7:0] mode_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_r <= MODE_RST;
      end else if (host_clr) begin
         mode_r <= MODE_RST;
      end else if (mode_we) begin
         mode_r <= (i_wdata & MODE_WR_MASK) | (mode_r & ~MODE_WR_MASK);
      end
   end

   // ****************************************
   // factory test locations
   // ****************************************
   // kept as plain storage; their meaning is not for host use
   logic [7:0] test_r [NUM_TEST];
   logic [7:0] test_idx [NUM_TEST];
   assign test_idx[0] = IDX_TEST_A;
   assign test_idx[1] = IDX_TEST_B;
   assign test_idx[2] = IDX_TEST_C;
   assign test_idx[3] = IDX_TEST_D;
   assign test_idx[4] = IDX_TEST_E;
   assign test_idx[5] = IDX_TEST_F;
   logic [NUM_TEST-1:0] test_we;
   genvar t;
   generate
      for (t = 0; t < NUM_TEST; t++) begin : g_test
         assign test_we[t] = wr && index_r == test_idx[t];
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               test_r[t] <= TEST_RST;
            end else if (test_we[t]) begin
               test_r[t] <= i_wdata;
            end
         end
      end
   endgenerate

   // ****************************************
   // reserved offsets
   // ****************************************
   // explicit, so a register added to the case later cannot leak into a hole
   localparam logic [7:0] RSVD_A_HI = 8'h06;
   localparam logic [7:0] RSVD_B_LO = 8'h08;
   localparam logic [7:0] RSVD_B_HI = 8'h1f;
   localparam logic [7:0] RSVD_C_LO = 8'h22;
   localparam logic [7:0] RSVD_C_HI = 8'h23;
   localparam logic [7:0] RSVD_D_LO = 8'h25;
   localparam logic [7:0] RSVD_D_HI = 8'h27;
   localparam logic [7:0] RSVD_E_LO = 8'h2a;
   localparam logic [7:0] RSVD_E_HI = 8'h2b;
   logic rsvd_hit;
   assign rsvd_hit = index_r inside {[ZERO_BYTE:RSVD_A_HI], [RSVD_B_LO:RSVD_B_HI],
      [RSVD_C_LO:RSVD_C_HI], [RSVD_D_LO:RSVD_D_HI], [RSVD_E_LO:RSVD_E_HI]};

   // ****************************************
   // read path
   // ****************************************
   logic [7:0] rd_nxt;
   always_comb begin
      rd_nxt = ZERO_BYTE;
      unique case (index_r)
         IDX_LDEV_SEL: rd_nxt = ldev_r;
         IDX_CHIP_ID: rd_nxt = CHIP_ID;
         IDX_SI_REV: rd_nxt = SI_REV;
         IDX_MODE: rd_nxt = mode_r;
         IDX_TEST_A: rd_nxt = test_r[0];
         IDX_TEST_B: rd_nxt = test_r[1];
         IDX_TEST_C: rd_nxt = test_r[2];
         IDX_TEST_D: rd_nxt = test_r[3];
         IDX_TEST_E: rd_nxt = test_r[4];
         IDX_TEST_F: rd_nxt = test_r[5];
         default: rd_nxt = ZERO_BYTE;
      endcase
      if (rsvd_hit) begin
         rd_nxt = ZERO_BYTE;
      end
   end

   logic [7:0] rdata_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_r <= ZERO_BYTE;
      end else if (i_data_re) begin
         rdata_r <= rd_nxt;
      end
   end

   // ****************************************
   // activation
   // ****************************************
   activate_bank #(
      .NUM_LDEV(NUM_LDEV)
   ) u_act (
      .i_clk(i_clk),
      .i_sys_rstn(sys_s2_r),
      .i_host_rstn(host_s2_r),
      .i_ldev_sel(ldev_r),
      .i_act_we(i_act_we),
      .i_act_val(i_act_val),
      .i_power_sel(i_power_sel),
      .o_active(o_active)
   );

   assign o_rdata = rdata_r;
   assign o_index = index_r;
   assign o_ldev_sel = ldev_r;
   assign o_interrupt_serializer_enable = mode_r[MODE_SIRQ_BIT];
endmodule
`default_nettype wire

// File: test/cfg_bank_props.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_bank_props
   import cfg_bank_pkg::*;
#(
   parameter int NUM_LDEV = 16,
   parameter logic [7:0] CHIP_ID = 8'h00,
   parameter logic [7:0] SI_REV = 8'h00
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_host_domain_reset_n,
   input wire logic i_index_we,
   input wire logic i_data_we,
   input wire logic i_data_re,
   input wire logic [7:0] i_wdata,
   input wire logic i_act_we,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_index,
   input wire logic [7:0] o_ldev_sel,
   input wire logic o_interrupt_serializer_enable,
   input wire logic [NUM_LDEV-1:0] o_active
);
   // ******
   // port relations
   // ******
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   // a data write that collides with an index write is dropped
   wire logic dw = i_data_we && !i_index_we;
   idx_load_a: assert property (i_index_we |=> o_index == $past(i_wdata))
      else $error("index not loaded");
   // a host-domain reset legitimately clears the index a few cycles later
   idx_hold_a: assert property (!i_index_we && i_host_domain_reset_n
      && $past(i_host_domain_reset_n) && $past(i_host_domain_reset_n, 2) |=> $stable(o_index))
      else $error("index moved");
   sel_load_a: assert property (dw && o_index == IDX_LDEV_SEL
      |=> o_ldev_sel == $past(i_wdata)) else $error("selector not loaded");
   mode_wr_a: assert property (dw && o_index == IDX_MODE
      |=> o_interrupt_serializer_enable == $past(i_wdata[MODE_SIRQ_BIT])) else $error("mode bit");
   mode_rd_a: assert property (i_data_re && o_index == IDX_MODE
      |=> o_rdata == {5'h00, $past(o_interrupt_serializer_enable), 2'h0}) else $error("mode read");
   chip_id_a: assert property (i_data_re && o_index == IDX_CHIP_ID |=> o_rdata == CHIP_ID)
      else $error("id read");
   rev_rd_a: assert property (i_data_re && o_index == IDX_SI_REV |=> o_rdata == SI_REV)
      else $error("revision read");
   rsvd_zero_a: assert property (i_data_re && o_index inside
      {[8'h00:8'h06], [8'h08:8'h1f], 8'h22, 8'h23, [8'h25:8'h27], 8'h2a, 8'h2b}
      |=> o_rdata == ZERO_BYTE) else $error("reserved read");
   act_only_a: assert property (i_act_we
      |=> ((o_active ^ $past(o_active)) & ~(NUM_LDEV'(1) << $past(o_ldev_sel))) == '0)
      else $error("other device changed");
endmodule
bind global_config_register_bank cfg_bank_props #(.NUM_LDEV(NUM_LDEV), .CHIP_ID(CHIP_ID),
   .SI_REV(SI_REV)) u_props (.i_clk, .i_rstn, .i_host_domain_reset_n, .i_index_we,
   .i_data_we, .i_data_re, .i_wdata,
   .i_act_we, .o_rdata, .o_index, .o_ldev_sel, .o_interrupt_serializer_enable, .o_active);
`default_nettype wire

// File: test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic o_index_we,
   output logic o_data_we,
   output logic o_data_re,
   output logic [7:0] o_wdata
);
   // ******
   // index and data port cycles
   // ******
   initial {o_index_we, o_data_we, o_data_re, o_wdata} = '0;
   // kind 0 index write, 1 data write, 2 data read; index must precede data use
   task automatic access(input logic [1:0] kind, input logic [7:0] v, output logic [7:0] rd);
      @(posedge i_clk);
      {o_index_we, o_data_we, o_data_re} <= {kind == 2'd0, kind == 2'd1, kind == 2'd2};
      o_wdata <= v;
      @(posedge i_clk);
      {o_index_we, o_data_we, o_data_re} <= 3'h0;
      // released bus must not look like held data
      o_wdata <= ~v;
      #1 rd = i_rdata;
   endtask
endmodule
`default_nettype wire

// File: test/global_config_register_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module global_config_register_bank_tb import cfg_bank_pkg::*;;
   logic clk, rstn, sys_n, host_n, act_we, act_val, idx_we, dwe, dre, sirq;
   logic [7:0] wd, o_rd, idx_q, ldev_q, ldev_m, mode_m, w, r;
   logic [3:0] psel, act, act_m;
   int err_total, num_checks;
   global_config_register_bank #(.NUM_LDEV(4)) i_dut (.i_clk(clk), .i_rstn(rstn),
      .i_system_reset_n(sys_n), .i_host_domain_reset_n(host_n), .i_index_we(idx_we),
      .i_data_we(dwe), .i_data_re(dre), .i_wdata(wd), .i_act_we(act_we), .i_act_val(act_val),
      .i_power_sel(psel), .o_rdata(o_rd), .o_index(idx_q), .o_ldev_sel(ldev_q),
      .o_interrupt_serializer_enable(sirq), .o_active(act));
   host_model u_host (.i_clk(clk), .i_rdata(o_rd), .o_index_we(idx_we), .o_data_we(dwe),
      .o_data_re(dre), .o_wdata(wd));
   // ******
   // expectations and sequences
   // ******
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [7:0] exp_rd(input logic [7:0] i);
      case (i)
         IDX_LDEV_SEL: return ldev_m;
         IDX_CHIP_ID: return CHIP_ID_DEFAULT;
         IDX_SI_REV: return SI_REV_DEFAULT;
         IDX_MODE: return mode_m;
         default: return ZERO_BYTE;
      endcase
   endfunction
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic do_reg(input logic [7:0] i, input logic [7:0] v);
      u_host.access(2'd0, i, r);
      u_host.access(2'd1, v, r);
      if (i == IDX_LDEV_SEL) ldev_m = v;
      if (i == IDX_MODE) mode_m = v & MODE_WR_MASK;
      u_host.access(2'd2, 8'h00, r);
      `CHK(r, exp_rd(i))
      u_host.access(2'd2, 8'h00, r);
      `CHK(r, exp_rd(i))
      `CHK({idx_q, ldev_q, sirq}, {i, ldev_m, mode_m[2]})
   endtask
   task automatic act_cmd(input int d);
      do_reg(IDX_LDEV_SEL, 8'(d));
      @(posedge clk);
      act_we <= 1'b1;
      act_val <= ~act_m[d];
      @(posedge clk);
      act_we <= 1'b0;
      act_m[d] = ~act_m[d];
      @(posedge clk);
      `CHK(act, act_m)
   endtask
   initial begin
      {rstn, sys_n, host_n, act_we, act_val} = '0;
      void'($urandom(63077));
      psel = 4'($urandom);
      {ldev_m, mode_m, act_m} = {LDEV_RST, MODE_RST, 4'h0};
      repeat (10) @(posedge clk);
      {rstn, sys_n, host_n} <= 3'h7;
      repeat (4) @(posedge clk);
      `CHK({idx_q, sirq, act}, {INDEX_RST, 1'b1, 4'h0})
      do_reg(IDX_MODE, 8'hfb);
      for (int k = 0; k < 2 * 8'h32; k++) begin
         w = 8'(k % 8'h32);
         // factory test offsets are left alone
         if (!(w inside {[8'h28:8'h29], [8'h2c:8'h2f]})) do_reg(w, 8'($urandom));
      end
      for (int d = 0; d < 4; d++) act_cmd(d);
      act_cmd(2);
      sys_n <= 1'b0;
      repeat (4) @(posedge clk);
      sys_n <= 1'b1;
      act_m = act_m & psel;
      repeat (4) @(posedge clk);
      `CHK(act, act_m)
      for (int d = 0; d < 4; d++) act_cmd(d);
      host_n <= 1'b0;
      repeat (4) @(posedge clk);
      host_n <= 1'b1;
      act_m = act_m & ~psel;
      {ldev_m, mode_m} = {LDEV_RST, MODE_RST};
      repeat (4) @(posedge clk);
      `CHK(act, act_m)
      `CHK({idx_q, ldev_q, sirq}, {INDEX_RST, ldev_m, mode_m[2]})
      print_verdict();
   end
   initial begin
      #900000;
      err_total++;
      print_verdict();
   end
endmodule
`default_nettype wire
